// ---- include/wsb_pkg.sv ----
package wsb_pkg;
	// Serial frame bytes and command codes
	localparam logic [7:0] SYNC_BYTE  = 8'h55;
	localparam logic [7:0] CR_BYTE    = 8'h0d;
	localparam logic [7:0] RSV_BYTE   = 8'h00;
	localparam logic [7:0] TIME_BYTE  = 8'h00;
	localparam logic [7:0] LEVEL_ONE  = 8'hff;
	localparam logic [7:0] LEVEL_ZERO = 8'h00;
	localparam logic [7:0] CMD_WG     = 8'h01;
	localparam logic [7:0] CMD_TAMP   = 8'h02;
	localparam logic [7:0] CMD_AUX0   = 8'h03;
	localparam logic [7:0] CMD_AUX1   = 8'h04;
	localparam logic [7:0] CMD_EE_WR  = 8'h09;
	localparam logic [7:0] CMD_RST    = 8'h0a;
	localparam logic [7:0] CMD_DUMP   = 8'h0b;
	// Frame lengths in bytes, and bytes that follow the command code
	localparam logic [4:0] LEN_WG     = 5'd20;
	localparam logic [4:0] LEN_SHORT  = 5'd6;
	localparam logic [4:0] BODY_WG    = 5'd17;
	localparam logic [4:0] BODY_SHORT = 5'd3;
	// Wiegand frame size limits
	localparam logic [6:0] WG_MIN_BITS = 7'd6;
	localparam logic [6:0] WG_MAX_BITS = 7'd96;
	// Timing
	localparam int CLK_MHZ      = 100;
	localparam int WG_IDLE_US   = 5000;
	localparam int WG_PULSE_US  = 100;
	localparam int WG_PERIOD_US = 1000;
	localparam int WG_IDLE_CYC   = WG_IDLE_US * CLK_MHZ;
	localparam int WG_PULSE_CYC  = WG_PULSE_US * CLK_MHZ;
	localparam int WG_PERIOD_CYC = WG_PERIOD_US * CLK_MHZ;
	localparam int SETTLE_CYC    = 3;
	// Pin synchroniser lanes and their reset levels (Wiegand lines idle high)
	localparam int SY_D0 = 0;
	localparam int SY_D1 = 1;
	localparam int SY_TAMP = 2;
	localparam int SY_AUX0 = 3;
	localparam int SY_AUX1 = 4;
	localparam int SY_MODE = 5;
	localparam logic [5:0] SYNC_RST = 6'h03;

	typedef enum logic [1:0] {
		P_SYNC1 = 2'b00,
		P_SYNC2 = 2'b01,
		P_ID    = 2'b10,
		P_BODY  = 2'b11
	} wsb_prs_e;

	typedef enum logic [1:0] {
		W_IDLE = 2'b00,
		W_LOW  = 2'b01,
		W_GAP  = 2'b10
	} wsb_wtx_e;
endpackage : wsb_pkg

// ---- src/wsb_bridge.sv ----
`timescale 1ns/1ps
module wsb_bridge
	import wsb_pkg::*;
#(
	parameter int WG_IDLE_CYC   = wsb_pkg::WG_IDLE_CYC,
	parameter int WG_PULSE_CYC  = wsb_pkg::WG_PULSE_CYC,
	parameter int WG_PERIOD_CYC = wsb_pkg::WG_PERIOD_CYC
) (
	input  logic       I_CLK_SYS,
	input  logic       I_RESETN,
	input  logic       I_MODE_SENSE,
	input  logic       I_WG_D0_N,
	input  logic       I_WG_D1_N,
	output logic       O_WG_D0_N,
	output logic       O_WG_D1_N,
	output logic       O_WG_OE,
	input  logic       I_TAMPER,
	output logic       O_TAMPER,
	input  logic       I_AUX_LINE_ZERO,
	output logic       O_AUX_LINE_ZERO,
	output logic       O_AUX_LINE_ZERO_OE,
	input  logic       I_AUX_LINE_ONE,
	output logic       O_AUX_LINE_ONE,
	output logic       O_AUX_LINE_ONE_OE,
	input  logic [7:0] I_RX_BYTE,
	input  logic       I_RX_VALID,
	output logic       O_RX_READY,
	output logic [7:0] O_TX_BYTE,
	output logic       O_TX_VALID,
	input  logic       I_TX_READY,
	output logic       O_RX_MODE
);
	import wsb_pkg::*;

	localparam logic [23:0] IDLE_C  = 24'(WG_IDLE_CYC - 1);
	localparam logic [23:0] PULSE_C = 24'(WG_PULSE_CYC - 1);
	localparam logic [23:0] GAP_C   = 24'(WG_PERIOD_CYC - WG_PULSE_CYC - 1);

	typedef struct packed {
		logic [5:0]   meta;
		logic [5:0]   sync;
		logic [1:0]   wprev;
		logic [2:0]   lvl_prev;
		logic [1:0]   settle;
		logic         mode_set;
		logic         rx_mode;
		wsb_prs_e     prs;
		logic [4:0]   left_rx;
		logic [7:0]   cmd;
		logic [135:0] body;
		logic [95:0]  wrx_bits;
		logic [6:0]   wrx_cnt;
		logic [23:0]  wrx_tmr;
		logic         wrx_act;
		logic         pend_wg;
		logic         pend_tamp;
		logic         pend_aux0;
		logic         pend_aux1;
		logic [159:0] tx_buf;
		logic [4:0]   tx_left;
		wsb_wtx_e     wst;
		logic [95:0]  wtx_bits;
		logic [6:0]   wtx_cnt;
		logic [23:0]  wtx_tmr;
		logic         wg_d0_n;
		logic         wg_d1_n;
		logic         tamper_out;
		logic         aux0_out;
		logic         aux1_out;
		logic         rx_ready;
		logic         wg_oe;
		logic         aux_oe;
	} wsb_state_s;

	wsb_state_s   r, n;
	logic         buf_in_ready;
	logic         buf_in_valid;
	logic [7:0]   buf_in_data;
	logic         push;
	logic         rx_acc;
	logic         fall0;
	logic         fall1;
	logic [135:0] body_full;
	logic [7:0]   nb;
	logic         val;

	function automatic logic [159:0] short_frame(input logic [7:0] cmd, input logic lvl);
		short_frame = {SYNC_BYTE, SYNC_BYTE, cmd, lvl ? LEVEL_ONE : LEVEL_ZERO, RSV_BYTE, CR_BYTE, 112'h0};
	endfunction : short_frame

	assign buf_in_valid = r.tx_left != 5'd0;
	assign buf_in_data  = r.tx_buf[159:152];
	assign push         = buf_in_valid & buf_in_ready;
	assign rx_acc       = I_RX_VALID & r.rx_ready;
	assign fall0        = r.wprev[0] & ~r.sync[SY_D0];
	assign fall1        = r.wprev[1] & ~r.sync[SY_D1];
	assign body_full    = {r.body[127:0], I_RX_BYTE};
	assign nb           = body_full[135:128];
	assign val          = body_full[23:16] != LEVEL_ZERO;

	always_comb begin
		n = r;
		n.meta     = {I_MODE_SENSE, I_AUX_LINE_ONE, I_AUX_LINE_ZERO, I_TAMPER, I_WG_D1_N, I_WG_D0_N};
		n.sync     = r.meta;
		n.wprev    = r.sync[SY_D1:SY_D0];
		n.lvl_prev = r.sync[SY_AUX1:SY_TAMP];

		// Mode is caught once the sense pin has passed the synchroniser
		if (!r.mode_set) begin
			if (r.settle == 2'(SETTLE_CYC)) begin
				n.mode_set = 1'b1;
				n.rx_mode  = r.sync[SY_MODE];
			end else begin
				n.settle = r.settle + 2'd1;
			end
		end

		// Byte stream out to the host, first byte of the frame first
		if (push) begin
			n.tx_buf  = {r.tx_buf[151:0], 8'h00};
			n.tx_left = r.tx_left - 5'd1;
		end

		// One report at a time; a pending event waits for the previous frame
		if (r.tx_left == 5'd0) begin
			if (r.pend_wg) begin
				n.tx_buf   = {SYNC_BYTE, SYNC_BYTE, CMD_WG, {1'b0, r.wrx_cnt}, r.wrx_bits,
				              TIME_BYTE, TIME_BYTE, RSV_BYTE, CR_BYTE};
				n.tx_left  = LEN_WG;
				n.pend_wg  = 1'b0;
				n.wrx_cnt  = 7'd0;
				n.wrx_bits = '0;
			end else if (r.pend_tamp) begin
				n.tx_buf    = short_frame(CMD_TAMP, r.lvl_prev[0]);
				n.tx_left   = LEN_SHORT;
				n.pend_tamp = 1'b0;
			end else if (r.pend_aux0) begin
				n.tx_buf    = short_frame(CMD_AUX0, r.lvl_prev[1]);
				n.tx_left   = LEN_SHORT;
				n.pend_aux0 = 1'b0;
			end else if (r.pend_aux1) begin
				n.tx_buf    = short_frame(CMD_AUX1, r.lvl_prev[2]);
				n.tx_left   = LEN_SHORT;
				n.pend_aux1 = 1'b0;
			end
		end

		// Level changes are set after the launch above, so a new change wins over the clear
		if (r.mode_set && r.rx_mode && r.sync[SY_TAMP] != r.lvl_prev[0]) begin
			n.pend_tamp = 1'b1;
		end
		if (r.mode_set && !r.rx_mode) begin
			if (r.sync[SY_AUX0] != r.lvl_prev[1]) begin
				n.pend_aux0 = 1'b1;
			end
			if (r.sync[SY_AUX1] != r.lvl_prev[2]) begin
				n.pend_aux1 = 1'b1;
			end
		end

		// Wiegand receive; bits arriving while a frame still waits are dropped
		if (r.mode_set && r.rx_mode && !r.pend_wg) begin
			if (fall0 ^ fall1) begin
				n.wrx_bits = {r.wrx_bits[94:0], fall1};
				if (r.wrx_cnt != 7'h7f) begin
					n.wrx_cnt = r.wrx_cnt + 7'd1;
				end
				n.wrx_tmr = 24'h0;
				n.wrx_act = 1'b1;
			end else if (r.wrx_act) begin
				n.wrx_tmr = r.wrx_tmr + 24'h1;
				if (r.wrx_tmr == IDLE_C) begin
					n.wrx_act = 1'b0;
					if (r.wrx_cnt >= WG_MIN_BITS && r.wrx_cnt <= WG_MAX_BITS) begin
						n.pend_wg = 1'b1;
					end else begin
						n.wrx_cnt  = 7'd0;
						n.wrx_bits = '0;
					end
				end
			end
		end

		// Command parser
		if (rx_acc) begin
			case (r.prs)
				P_SYNC1: begin
					if (I_RX_BYTE == SYNC_BYTE) begin
						n.prs = P_SYNC2;
					end
				end
				P_SYNC2: begin
					n.prs = (I_RX_BYTE == SYNC_BYTE) ? P_ID : P_SYNC1;
				end
				P_ID: begin
					n.cmd = I_RX_BYTE;
					if (I_RX_BYTE == CMD_WG) begin
						n.left_rx = BODY_WG;
						n.prs     = P_BODY;
					end else if (I_RX_BYTE == CMD_TAMP || I_RX_BYTE == CMD_AUX0 || I_RX_BYTE == CMD_AUX1) begin
						n.left_rx = BODY_SHORT;
						n.prs     = P_BODY;
					end else begin
						// Reserved codes, and the storage and restart commands, have no action here
						n.prs = P_SYNC1;
					end
				end
				P_BODY: begin
					n.body    = body_full;
					n.left_rx = r.left_rx - 5'd1;
					if (r.left_rx == 5'd1) begin
						n.prs = P_SYNC1;
						// Reserved byte is carried in body but never read
						if (I_RX_BYTE == CR_BYTE) begin
							case (r.cmd)
								CMD_WG: begin
									if (!r.rx_mode && nb >= 8'(WG_MIN_BITS) && nb <= 8'(WG_MAX_BITS)) begin
										n.wtx_bits = body_full[127:32] << (WG_MAX_BITS - nb[6:0]);
										n.wtx_cnt  = nb[6:0];
										n.wtx_tmr  = 24'h0;
										n.wst      = W_LOW;
									end
								end
								CMD_TAMP: begin
									if (!r.rx_mode) begin
										n.tamper_out = val;
									end
								end
								CMD_AUX0: begin
									if (r.rx_mode) begin
										n.aux0_out = val;
									end
								end
								CMD_AUX1: begin
									if (r.rx_mode) begin
										n.aux1_out = val;
									end
								end
								default: begin
								end
							endcase
						end
					end
				end
				default: n.prs = P_SYNC1;
			endcase
		end

		// Wiegand transmit, most significant bit first
		case (r.wst)
			W_IDLE: begin
			end
			W_LOW: begin
				n.wtx_tmr = r.wtx_tmr + 24'h1;
				if (r.wtx_tmr == PULSE_C) begin
					n.wtx_tmr = 24'h0;
					n.wst     = W_GAP;
				end
			end
			W_GAP: begin
				n.wtx_tmr = r.wtx_tmr + 24'h1;
				if (r.wtx_tmr == GAP_C) begin
					n.wtx_tmr  = 24'h0;
					n.wtx_bits = {r.wtx_bits[94:0], 1'b0};
					n.wtx_cnt  = r.wtx_cnt - 7'd1;
					n.wst      = (r.wtx_cnt == 7'd1) ? W_IDLE : W_LOW;
				end
			end
			default: n.wst = W_IDLE;
		endcase
		n.wg_d0_n = !(n.wst == W_LOW && !n.wtx_bits[95]);
		n.wg_d1_n = !(n.wst == W_LOW && n.wtx_bits[95]);

		// Host commands are held off while a Wiegand frame is going out
		n.rx_ready = n.mode_set && n.wst == W_IDLE;
		n.wg_oe    = n.mode_set && !n.rx_mode;
		n.aux_oe   = n.mode_set && n.rx_mode;
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
		if (!I_RESETN) begin
			r          <= '0;
			r.meta     <= SYNC_RST;
			r.sync     <= SYNC_RST;
			r.wprev    <= 2'h3;
			r.prs      <= P_SYNC1;
			r.wst      <= W_IDLE;
			r.wg_d0_n  <= 1'b1;
			r.wg_d1_n  <= 1'b1;
		end else begin
			r <= n;
		end
	end

	wsb_skid #(
		.W(8)
	) u_tx_buf (
		.i_clk   (I_CLK_SYS),
		.i_rst_n (I_RESETN),
		.i_data  (buf_in_data),
		.i_valid (buf_in_valid),
		.o_ready (buf_in_ready),
		.o_data  (O_TX_BYTE),
		.o_valid (O_TX_VALID),
		.i_ready (I_TX_READY)
	);

	assign O_WG_D0_N          = r.wg_d0_n;
	assign O_WG_D1_N          = r.wg_d1_n;
	assign O_WG_OE            = r.wg_oe;
	assign O_TAMPER           = r.tamper_out;
	assign O_AUX_LINE_ZERO    = r.aux0_out;
	assign O_AUX_LINE_ONE     = r.aux1_out;
	assign O_AUX_LINE_ZERO_OE = r.aux_oe;
	assign O_AUX_LINE_ONE_OE  = r.aux_oe;
	assign O_RX_READY         = r.rx_ready;
	assign O_RX_MODE          = r.rx_mode;

	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RESETN);

	sequence take_s(logic [1:0] st);
		rx_acc && r.prs == st;
	endsequence
	sequence push_s(logic [4:0] k);
		push && r.tx_left == k;
	endsequence
	// A fresh report is loaded in the cycle after the byte counter was empty
	sequence launch_s;
		r.tx_left == 5'd0 ##1 r.tx_left != 5'd0;
	endsequence

	sync_hunt_a: assert property (take_s(P_SYNC1) and (I_RX_BYTE != SYNC_BYTE) |=> r.prs == P_SYNC1)
		else $error("non-sync byte left hunt state");
	id_after_sync_a: assert property (take_s(P_SYNC2) and (I_RX_BYTE == SYNC_BYTE) |=> r.prs == P_ID)
		else $error("code byte not expected after sync pair");
	bad_term_a: assert property (take_s(P_BODY) and (r.left_rx == 5'd1 && I_RX_BYTE != CR_BYTE)
		|=> $stable(O_TAMPER) && $stable(O_AUX_LINE_ZERO) && $stable(O_AUX_LINE_ONE) && $stable(r.wst))
		else $error("frame with bad terminator acted on");
	tx_head_a: assert property (launch_s |-> buf_in_data == SYNC_BYTE && r.tx_buf[151:144] == SYNC_BYTE)
		else $error("report does not open with sync");
	tx_tail_a: assert property (push_s(5'd2) |-> buf_in_data == RSV_BYTE ##1 (!push || buf_in_data == CR_BYTE))
		else $error("report tail malformed");
	wg_count_a: assert property (push_s(BODY_WG) |-> buf_in_data >= 8'(WG_MIN_BITS)
		&& buf_in_data <= 8'(WG_MAX_BITS))
		else $error("bit count out of range in report");
	one_low_a: assert property (!(!O_WG_D0_N && !O_WG_D1_N))
		else $error("both Wiegand lines low together");
	busy_hold_a: assert property (r.wst != W_IDLE |-> !O_RX_READY)
		else $error("host commands taken while Wiegand frame busy");
	tamp_report_a: assert property (r.mode_set && r.rx_mode && r.sync[SY_TAMP] != r.lvl_prev[0]
		|=> r.pend_tamp)
		else $error("tamper change not recorded");
	aux_dir_a: assert property (r.mode_set |-> O_AUX_LINE_ZERO_OE == r.rx_mode
		&& O_AUX_LINE_ONE_OE == r.rx_mode && O_WG_OE == !r.rx_mode)
		else $error("line direction does not follow mode");
endmodule : wsb_bridge

// ---- src/wsb_skid.sv ----
`timescale 1ns/1ps
module wsb_skid #(
	parameter int W = 8
) (
	input  logic         i_clk,
	input  logic         i_rst_n,
	input  logic [W-1:0] i_data,
	input  logic         i_valid,
	output logic         o_ready,
	output logic [W-1:0] o_data,
	output logic         o_valid,
	input  logic         i_ready
);
	typedef struct packed {
		logic         ov;
		logic [W-1:0] od;
		logic         sv;
		logic [W-1:0] sd;
	} wsb_skid_s;

	wsb_skid_s r, n;
	logic      push;
	logic      pop;

	assign push    = i_valid & ~r.sv;
	assign pop     = r.ov & i_ready;
	assign o_ready = ~r.sv;
	assign o_data  = r.od;
	assign o_valid = r.ov;

	// Second entry only fills while the head is stalled, so no word is lost
	always_comb begin
		n = r;
		if (pop || !r.ov) begin
			if (r.sv) begin
				n.od = r.sd;
				n.ov = 1'b1;
				n.sv = 1'b0;
			end else begin
				n.ov = push;
				n.od = i_data;
			end
		end else if (push) begin
			n.sv = 1'b1;
			n.sd = i_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
endmodule : wsb_skid

// ---- verif/wsb_bridge_tb.sv ----
`timescale 1ns/1ps
module wsb_bridge_tb;
	import wsb_pkg::*;
	typedef struct packed {
		logic [7:0] sync2;
		logic [7:0] code;
		logic [7:0] value;
		logic [7:0] term;
		logic       aux0;
		logic       aux1;
	} wsb_row_s;
	typedef logic [7:0] wsb_bytes_t[$];

	localparam int N_ROWS      = 15;
	localparam int TIMEOUT_CYC = 20000;

	logic       clk_sys;
	logic       resetn     = 1'b0;
	logic       mode_sense = 1'b1;
	logic       wg_d0_n;
	logic       wg_d1_n;
	logic       wgo_d0_n;
	logic       wgo_d1_n;
	logic       wg_oe;
	logic       tamper_in  = 1'b0;
	logic       tamper_out;
	logic       aux0_in    = 1'b0;
	logic       aux0_out;
	logic       aux0_oe;
	logic       aux1_in    = 1'b0;
	logic       aux1_out;
	logic       aux1_oe;
	logic [7:0] rx_byte    = 8'h00;
	logic       rx_valid   = 1'b0;
	logic       rx_ready;
	logic [7:0] tx_byte;
	logic       tx_valid;
	logic       tx_ready   = 1'b0;
	logic       rx_mode;
	logic [95:0] got_bits;
	wsb_bytes_t cmd_q;
	wsb_row_s   rows [N_ROWS];
	int         fails      = 0;
	int         n_compared = 0;
	int         cycles     = 0;

	wsb_bridge #(.WG_IDLE_CYC(50), .WG_PULSE_CYC(4), .WG_PERIOD_CYC(12)) u_dut (
		.I_CLK_SYS(clk_sys), .I_RESETN(resetn), .I_MODE_SENSE(mode_sense),
		.I_WG_D0_N(wg_d0_n), .I_WG_D1_N(wg_d1_n), .O_WG_D0_N(wgo_d0_n), .O_WG_D1_N(wgo_d1_n),
		.O_WG_OE(wg_oe), .I_TAMPER(tamper_in), .O_TAMPER(tamper_out),
		.I_AUX_LINE_ZERO(aux0_in), .O_AUX_LINE_ZERO(aux0_out), .O_AUX_LINE_ZERO_OE(aux0_oe),
		.I_AUX_LINE_ONE(aux1_in), .O_AUX_LINE_ONE(aux1_out), .O_AUX_LINE_ONE_OE(aux1_oe),
		.I_RX_BYTE(rx_byte), .I_RX_VALID(rx_valid), .O_RX_READY(rx_ready),
		.O_TX_BYTE(tx_byte), .O_TX_VALID(tx_valid), .I_TX_READY(tx_ready), .O_RX_MODE(rx_mode)
	);

	wsb_reader_model u_reader (
		.i_clk(clk_sys),
		.o_d0_n(wg_d0_n),
		.o_d1_n(wg_d1_n)
	);

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles >= TIMEOUT_CYC) begin
			fails++;
			summarize();
		end
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			fails++;
		end
	endtask : check

	function automatic wsb_bytes_t short_frame(input logic [7:0] code, input logic [7:0] val);
		return {SYNC_BYTE, SYNC_BYTE, code, val, RSV_BYTE, CR_BYTE};
	endfunction : short_frame

	// Data is right-justified in twelve bytes, most significant byte first
	function automatic wsb_bytes_t wg_frame(input logic [95:0] bits, input logic [7:0] nb);
		wsb_bytes_t q;
		q = {SYNC_BYTE, SYNC_BYTE, CMD_WG, nb};
		for (int i = 11; i >= 0; i--) q.push_back(bits[i*8 +: 8]);
		q = {q, TIME_BYTE, TIME_BYTE, RSV_BYTE, CR_BYTE};
		return q;
	endfunction : wg_frame

	// Entered just after a rising edge; ready is judged before the edge that takes the byte
	task automatic send_cmd(input wsb_bytes_t b);
		int k;
		rx_valid <= 1'b1;
		foreach (b[i]) begin
			rx_byte <= b[i];
			k = 0;
			do begin
				@(negedge clk_sys);
				k++;
			end while (rx_ready !== 1'b1 && k < 5000);
			@(posedge clk_sys);
		end
		rx_valid <= 1'b0;
	endtask : send_cmd

	// Stalls one cycle in three so the output buffer must hold its words
	task automatic expect_frame(input wsb_bytes_t e);
		wsb_bytes_t got;
		int k;
		k = 0;
		while (got.size() < e.size() && k < 2000) begin
			@(negedge clk_sys);
			if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_byte);
			@(posedge clk_sys);
			tx_ready <= (k % 3 != 2) && (got.size() < e.size());
			k++;
		end
		foreach (e[i]) check(i < got.size() ? got[i] : 8'hxx, e[i]);
	endtask : expect_frame

	task automatic cap_wg(input int nb, output logic [95:0] bits);
		logic p0;
		logic p1;
		int   n;
		int   k;
		bits = '0;
		p0 = 1'b1;
		p1 = 1'b1;
		n = 0;
		k = 0;
		while (n < nb && k < 3000) begin
			@(negedge clk_sys);
			k++;
			if ((p0 === 1'b1 && wgo_d0_n === 1'b0) || (p1 === 1'b1 && wgo_d1_n === 1'b0)) begin
				bits = {bits[94:0], (wgo_d1_n === 1'b0)};
				if (n == 0) check({7'h00, rx_ready}, 8'h00);
				n++;
			end
			p0 = wgo_d0_n;
			p1 = wgo_d1_n;
		end
	endtask : cap_wg

	task automatic do_reset(input logic mode);
		resetn <= 1'b0;
		mode_sense <= mode;
		repeat (5) @(posedge clk_sys);
		check({2'b00, wgo_d0_n, wgo_d1_n, wg_oe, tx_valid, rx_ready, tamper_out}, 8'h30);
		resetn <= 1'b1;
		repeat (8) @(posedge clk_sys);
	endtask : do_reset

	initial begin
		rows = '{
			'{8'h55, 8'h03, 8'hff, 8'h0d, 1'b1, 1'b0}, '{8'h55, 8'h04, 8'h01, 8'h0d, 1'b1, 1'b1},
			'{8'h55, 8'h03, 8'h00, 8'h0d, 1'b0, 1'b1}, '{8'h55, 8'h03, 8'hff, 8'h0c, 1'b0, 1'b1},
			'{8'h54, 8'h03, 8'hff, 8'h0d, 1'b0, 1'b1}, '{8'h55, 8'h02, 8'hff, 8'h0d, 1'b0, 1'b1},
			'{8'h55, 8'h00, 8'hff, 8'h0d, 1'b0, 1'b1}, '{8'h55, 8'h05, 8'hff, 8'h0d, 1'b0, 1'b1},
			'{8'h55, 8'h08, 8'hff, 8'h0d, 1'b0, 1'b1}, '{8'h55, 8'h09, 8'hff, 8'h0d, 1'b0, 1'b1},
			'{8'h55, 8'h0a, 8'hff, 8'h0d, 1'b0, 1'b1}, '{8'h55, 8'h0b, 8'hff, 8'h0d, 1'b0, 1'b1},
			'{8'h55, 8'h0c, 8'hff, 8'h0d, 1'b0, 1'b1}, '{8'h55, 8'hff, 8'hff, 8'h0d, 1'b0, 1'b1},
			'{8'h55, 8'h04, 8'h00, 8'h0d, 1'b0, 1'b0}};
		@(posedge clk_sys);
		do_reset(1'b1);
		check({4'h0, rx_mode, wg_oe, aux0_oe, aux1_oe}, 8'h0b);
		foreach (rows[i]) begin
			cmd_q = {SYNC_BYTE, rows[i].sync2, rows[i].code, rows[i].value, RSV_BYTE, rows[i].term};
			send_cmd(cmd_q);
			repeat (4) @(posedge clk_sys);
			check({5'h00, tamper_out, aux0_out, aux1_out}, {6'h00, rows[i].aux0, rows[i].aux1});
		end
		tamper_in <= 1'b1;
		expect_frame(short_frame(CMD_TAMP, LEVEL_ONE));
		// A 5-bit burst must be dropped, so the first report is the 26-bit frame
		u_reader.send_frame(96'h1f, 5);
		u_reader.send_frame(96'h2a5b3c1, 26);
		expect_frame(wg_frame(96'h2a5b3c1, 8'd26));

		do_reset(1'b0);
		check({4'h0, rx_mode, wg_oe, aux0_oe, aux1_oe}, 8'h04);
		send_cmd(short_frame(CMD_TAMP, 8'h5a));
		repeat (4) @(posedge clk_sys);
		send_cmd(short_frame(CMD_AUX0, LEVEL_ONE));
		repeat (4) @(posedge clk_sys);
		check({6'h00, tamper_out, aux0_out}, 8'h02);
		send_cmd(wg_frame(96'h2d, 8'd6));
		cap_wg(6, got_bits);
		check(got_bits[7:0], 8'h2d);
		@(posedge clk_sys);
		// An out-of-range count is dropped; the next frame's bits must come first
		send_cmd(wg_frame(96'h0, 8'd97));
		@(posedge clk_sys);
		send_cmd(wg_frame(96'h33, 8'd6));
		cap_wg(6, got_bits);
		check(got_bits[7:0], 8'h33);
		@(posedge clk_sys);
		aux1_in <= 1'b1;
		expect_frame(short_frame(CMD_AUX1, LEVEL_ONE));
		aux0_in <= 1'b1;
		expect_frame(short_frame(CMD_AUX0, LEVEL_ONE));
		// Both lines fall together: the line-zero report must go out first
		aux0_in <= 1'b0;
		aux1_in <= 1'b0;
		expect_frame(short_frame(CMD_AUX0, LEVEL_ZERO));
		expect_frame(short_frame(CMD_AUX1, LEVEL_ZERO));
		summarize();
	end
endmodule : wsb_bridge_tb

// ---- verif/wsb_reader_model.sv ----
`timescale 1ns/1ps
module wsb_reader_model #(
	parameter int LOW_CYC  = 3,
	parameter int HIGH_CYC = 9,
	parameter int GAP_CYC  = 120
) (
	input  wire logic i_clk,
	output logic      o_d0_n,
	output logic      o_d1_n
);
	// Lines rest high through their pull-ups
	initial begin
		o_d0_n = 1'b1;
		o_d1_n = 1'b1;
	end

	// Sends bits [nb-1:0], highest first
	task automatic send_frame(input logic [95:0] bits, input int nb);
		for (int i = nb - 1; i >= 0; i--) begin
			@(posedge i_clk);
			if (bits[i]) begin
				o_d1_n <= 1'b0;
			end else begin
				o_d0_n <= 1'b0;
			end
			repeat (LOW_CYC) @(posedge i_clk);
			o_d0_n <= 1'b1;
			o_d1_n <= 1'b1;
			repeat (HIGH_CYC - 1) @(posedge i_clk);
		end
		// Quiet time so the bridge can forward one frame before the next starts
		repeat (GAP_CYC) @(posedge i_clk);
	endtask : send_frame
endmodule : wsb_reader_model
